/* uoed_pkg.sv */
// ==========================================================================
// descriptor map, field positions and codes
package uoed_pkg;

    localparam int          AXI_AW        = 7;      // byte address width
    localparam int          IDX_W         = 5;      // {endpoint, offset}
    localparam logic [2:0]  OFS_CONFIG    = 3'h0;
    localparam logic [2:0]  OFS_X_BASE    = 3'h1;
    localparam logic [2:0]  OFS_X_COUNT   = 3'h2;
    localparam logic [2:0]  OFS_SPARE_A   = 3'h3;
    localparam logic [2:0]  OFS_SPARE_B   = 3'h4;
    localparam logic [2:0]  OFS_Y_BASE    = 3'h5;
    localparam logic [2:0]  OFS_Y_COUNT   = 3'h6;
    localparam logic [2:0]  OFS_SIZE      = 3'h7;
    localparam logic [1:0]  EP_NONE       = 2'h0;   // endpoints are 1 to 3
    localparam int          CNT_NAK_BIT   = 7;
    localparam int          SIZE_RSV_BIT  = 7;
    localparam int          CNF_STALL_BIT = 3;
    localparam int          CNF_DBUF_BIT  = 4;
    localparam int          CNF_TOGGLE_BIT = 5;
    localparam int          CNF_UBME_BIT  = 7;
    localparam logic [2:0]  BASE_PAD      = 3'h0;   // low address bits appended
    localparam logic [6:0]  MAX_COUNT     = 7'h40;
    localparam logic [7:0]  DESC_RESET    = 8'h00;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_NONE} uoed_hs_t;

    // decode of a register index into "is an implemented entry"
    function automatic logic uoed_mapped(input logic [IDX_W-1:0] idx);
        return (idx[4:3] != EP_NONE) && (idx[2:0] != OFS_SPARE_A)
            && (idx[2:0] != OFS_SPARE_B);
    endfunction

endpackage

/* uoed_mem_if.sv */
// ==========================================================================
// one port of the descriptor memory
interface uoed_mem_if;
    logic [4:0] addr;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport user (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface

/* uoed_desc_mem.sv */
// ==========================================================================
// descriptor storage, two ports, registered read data
module uoed_desc_mem
    import uoed_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    uoed_mem_if.mem   pa,
    uoed_mem_if.mem   pb
);
    logic [7:0] mem_q [32];
    logic [7:0] ra_q;
    logic [7:0] rb_q;

    // writes; port b wins a same-address collision
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 32; i++) begin
                mem_q[i] <= DESC_RESET;
            end
        end else if (ce) begin
            if (pa.we) begin
                mem_q[pa.addr] <= pa.wdata;
            end
            if (pb.we) begin
                mem_q[pb.addr] <= pb.wdata;
            end
        end
    end

    // read registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ra_q <= DESC_RESET;
            rb_q <= DESC_RESET;
        end else if (ce) begin
            ra_q <= mem_q[pa.addr];
            rb_q <= mem_q[pb.addr];
        end
    end

    assign pa.rdata = ra_q;
    assign pb.rdata = rb_q;
endmodule

/* uoed_top.sv */
module uoed_top
    import uoed_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                pkt_start,
    input  wire logic [1:0]          pkt_ep,
    input  wire logic                pkt_byte_valid,
    input  wire logic [7:0]          pkt_byte,
    input  wire logic                pkt_end,
    output logic                     pkt_ready,
    output logic                     hs_valid,
    output uoed_hs_t                 hs_code,
    output logic                     buf_wr_en,
    output logic [10:0]              buf_wr_addr,
    output logic [7:0]               buf_wr_data
);
    // ======================================================================
    // register bus slave
    uoed_mem_if ma ();
    uoed_mem_if mb ();

    logic [IDX_W-1:0] aw_idx_q;
    logic             aw_have_q;
    logic [7:0]       w_byte_q;
    logic             w_lane_q;
    logic             w_have_q;
    logic [IDX_W-1:0] ar_idx_q;
    logic [1:0]       rd_st_q;     // 0 idle, 1 waiting for port, 2 read issued
    logic             do_write;
    logic             rd_issue;

    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign rd_issue = (rd_st_q == 2'd1) && !do_write;

    // write address and data are taken independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_idx_q     <= '0;
            w_byte_q     <= DESC_RESET;
            w_lane_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[AXI_AW-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= uoed_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ready flags registered so every output comes from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= (rd_st_q == 2'd0) && !s_axi_rvalid
                             && !(s_axi_arvalid && s_axi_arready);
        end
    end

    // read path: index, memory read, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_q      <= 2'd0;
            ar_idx_q     <= '0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_idx_q <= s_axi_araddr[AXI_AW-1:2];
                rd_st_q  <= 2'd1;
            end else if (rd_issue) begin
                rd_st_q <= 2'd2;
            end else if (rd_st_q == 2'd2) begin
                rd_st_q      <= 2'd0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= uoed_mapped(ar_idx_q) ? {24'h00_0000, ma.rdata}
                                                     : 32'h0000_0000;
                s_axi_rresp  <= uoed_mapped(ar_idx_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // port a: firmware reads and writes, size reserved bit forced low
    assign ma.addr  = do_write ? aw_idx_q : ar_idx_q;
    assign ma.we    = do_write && w_lane_q && uoed_mapped(aw_idx_q);
    assign ma.wdata = (aw_idx_q[2:0] == OFS_SIZE) ? {1'b0, w_byte_q[6:0]}
                                                  : w_byte_q;

    // ======================================================================
    // out packet engine
    typedef enum logic [3:0] {E_IDLE, E_CNF, E_CNT, E_BASE, E_SIZE, E_DEC,
                              E_RECV, E_DRAIN, E_WCNT, E_WCNF} uoed_st_t;
    uoed_st_t   st_q;
    uoed_st_t   st_d;
    logic [1:0] ep_q;
    logic [7:0] cnf_q;
    logic [7:0] cnt_q;
    logic [7:0] base_q;
    logic [6:0] size_q;
    logic       use_y_q;
    logic [6:0] idx_q;
    uoed_hs_t   hs_kind_q;
    logic       cnf_y;

    assign cnf_y = mb.rdata[CNF_DBUF_BIT] && mb.rdata[CNF_TOGGLE_BIT];

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            E_IDLE:  if (pkt_start) st_d = E_CNF;
            E_CNF:   st_d = E_CNT;
            E_CNT:   st_d = E_BASE;
            E_BASE:  st_d = E_SIZE;
            E_SIZE:  st_d = E_DEC;
            E_DEC: begin
                if (!cnf_q[CNF_UBME_BIT] || cnf_q[CNF_STALL_BIT]
                    || cnt_q[CNT_NAK_BIT]) begin
                    st_d = E_DRAIN;
                end else begin
                    st_d = E_RECV;
                end
            end
            E_RECV:  if (pkt_end) st_d = E_WCNT;
            E_DRAIN: if (pkt_end) st_d = E_IDLE;
            E_WCNT:  st_d = cnf_q[CNF_DBUF_BIT] ? E_WCNF : E_IDLE;
            E_WCNF:  st_d = E_IDLE;
            default: st_d = E_IDLE;
        endcase
    end

    // descriptor fetch and decision
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q      <= E_IDLE;
            ep_q      <= EP_NONE;
            cnf_q     <= DESC_RESET;
            cnt_q     <= DESC_RESET;
            base_q    <= DESC_RESET;
            size_q    <= '0;
            use_y_q   <= 1'b0;
            hs_kind_q <= HS_NONE;
            pkt_ready <= 1'b0;
        end else if (ce) begin
            st_q      <= st_d;
            pkt_ready <= (st_d == E_IDLE) || (st_d == E_RECV) || (st_d == E_DRAIN);
            case (st_q)
                E_IDLE:  ep_q <= pkt_ep;
                E_CNT: begin
                    cnf_q   <= mb.rdata;
                    use_y_q <= cnf_y;
                end
                E_BASE:  cnt_q  <= mb.rdata;
                E_SIZE:  base_q <= mb.rdata;
                E_DEC: begin
                    size_q <= mb.rdata[6:0];
                    if (!cnf_q[CNF_UBME_BIT] || ep_q == EP_NONE) begin
                        hs_kind_q <= HS_NONE;
                    end else if (cnf_q[CNF_STALL_BIT]) begin
                        hs_kind_q <= HS_STALL;
                    end else if (cnt_q[CNT_NAK_BIT]) begin
                        hs_kind_q <= HS_NAK;
                    end else begin
                        hs_kind_q <= HS_ACK;
                    end
                end
                default: ;
            endcase
        end
    end

    // port b: reads descriptor entries, writes count and config only
    always_comb begin
        mb.addr  = {ep_q, OFS_CONFIG};
        mb.we    = 1'b0;
        mb.wdata = cnf_q;
        case (st_q)
            E_CNT:   mb.addr = {ep_q, cnf_y ? OFS_Y_COUNT : OFS_X_COUNT};
            E_BASE:  mb.addr = {ep_q, use_y_q ? OFS_Y_BASE : OFS_X_BASE};
            E_SIZE:  mb.addr = {ep_q, OFS_SIZE};
            E_WCNT: begin
                mb.addr  = {ep_q, use_y_q ? OFS_Y_COUNT : OFS_X_COUNT};
                mb.we    = 1'b1;
                mb.wdata = {1'b1, idx_q};
            end
            E_WCNF: begin
                mb.we    = 1'b1;
                mb.wdata = cnf_q ^ (8'h01 << CNF_TOGGLE_BIT);
            end
            default: ;
        endcase
    end

    // data path into the shared buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_q       <= '0;
            buf_wr_en   <= 1'b0;
            buf_wr_addr <= '0;
            buf_wr_data <= DESC_RESET;
        end else if (ce) begin
            buf_wr_en <= 1'b0;
            if (st_q == E_DEC) begin
                idx_q <= '0;
            end else if (st_q == E_RECV && pkt_byte_valid && !pkt_end
                         && idx_q < size_q && idx_q < MAX_COUNT) begin
                buf_wr_en   <= 1'b1;
                buf_wr_addr <= {base_q, BASE_PAD} + {4'h0, idx_q};
                buf_wr_data <= pkt_byte;
                idx_q       <= idx_q + 7'h01;
            end
        end
    end

    // handshake towards the host at end of packet
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_valid <= 1'b0;
            hs_code  <= HS_NONE;
        end else if (ce) begin
            hs_valid <= 1'b0;
            if ((st_q == E_RECV || st_q == E_DRAIN) && pkt_end
                && hs_kind_q != HS_NONE) begin
                hs_valid <= 1'b1;
                hs_code  <= hs_kind_q;
            end
        end
    end

    uoed_desc_mem u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pa      (ma.mem),
        .pb      (mb.mem)
    );

    // ======================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    y_base_align_a: assert property (buf_wr_en && use_y_q |->
        buf_wr_addr == {base_q, 3'b000} + {4'h0, idx_q} - 11'h001)
        else $error("y buffer address not base plus offset");
    y_first_addr_a: assert property (buf_wr_en && use_y_q && idx_q == 7'h01 |->
        buf_wr_addr[10:3] == base_q && buf_wr_addr[2:0] == 3'b000)
        else $error("first y byte not at base");
    base_untouched_a: assert property (mb.we |->
        mb.addr[2:0] != OFS_X_BASE && mb.addr[2:0] != OFS_Y_BASE)
        else $error("engine wrote a base entry");
    empty_accept_a: assert property (st_q == E_DEC && cnf_q[CNF_UBME_BIT]
        && !cnf_q[CNF_STALL_BIT] && !cnt_q[CNT_NAK_BIT] |=> st_q == E_RECV
        && hs_kind_q == HS_ACK)
        else $error("empty buffer not accepted");
    full_nak_a: assert property (st_q == E_DEC && cnf_q[CNF_UBME_BIT]
        && !cnf_q[CNF_STALL_BIT] && cnt_q[CNT_NAK_BIT] |=> st_q == E_DRAIN
        && hs_kind_q == HS_NAK)
        else $error("full buffer not answered with nak");
    count_range_a: assert property (mb.we && mb.addr[1:0] == 2'b10 |->
        mb.wdata[CNT_NAK_BIT] && mb.wdata[6:0] <= MAX_COUNT)
        else $error("count write out of range");
    size_limit_a: assert property (buf_wr_en |-> idx_q <= size_q)
        else $error("write beyond buffer size");
    x_base_align_a: assert property (buf_wr_en && !use_y_q |->
        buf_wr_addr == {base_q, 3'b000} + {4'h0, idx_q} - 11'h001)
        else $error("x buffer address not base plus offset");
    stall_answer_a: assert property (st_q == E_DRAIN && hs_kind_q == HS_STALL
        && pkt_end |=> hs_valid && hs_code == HS_STALL)
        else $error("stall not answered");

    ack_seen_c:   cover property (hs_valid && hs_code == HS_ACK);
    nak_seen_c:   cover property (hs_valid && hs_code == HS_NAK);
    stall_seen_c: cover property (hs_valid && hs_code == HS_STALL);
endmodule

/* uoed_host_model.sv */
// ==========================================================================
// host side: sends out packets into the endpoint engine
module uoed_host_model (
    input  wire logic       aclk,
    input  wire logic       pkt_ready,
    output logic            pkt_start,
    output logic [1:0]      pkt_ep,
    output logic            pkt_byte_valid,
    output logic [7:0]      pkt_byte,
    output logic            pkt_end
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet lines at time zero
    initial begin
        pkt_start = 1'b0;
        pkt_ep = 2'h0;
        pkt_byte_valid = 1'b0;
        pkt_byte = 8'h00;
        pkt_end = 1'b0;
    end

    // hold the current request until an edge sees ready high
    task automatic wait_taken();
        do @(posedge aclk); while (pkt_ready !== 1'b1);
    endtask

    // one out packet; gap idles between bytes (slow host), stale lines inverted
    task automatic send(input logic [1:0] ep, input int n, input logic [7:0] first,
                        input int gap);
        logic [7:0] b;
        pkt_start <= 1'b1;
        pkt_ep <= ep;
        wait_taken();
        pkt_start <= 1'b0;
        pkt_ep <= ~ep;
        for (int i = 0; i < n; i++) begin
            b = first + i[7:0];
            pkt_byte_valid <= 1'b1;
            pkt_byte <= b;
            wait_taken();
            if (gap > 0 || i == n - 1) begin
                pkt_byte_valid <= 1'b0;
                pkt_byte <= ~b;
                repeat (gap) @(posedge aclk);
            end
        end
        pkt_end <= 1'b1;
        wait_taken();
        pkt_end <= 1'b0;
    endtask
endmodule

/* tb.sv */
// ==========================================================================
// self-checking bench for the out endpoint descriptor block
module tb
    import uoed_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, pkt_ep;
    logic pkt_start, pkt_byte_valid, pkt_end, pkt_ready, hs_valid, buf_wr_en;
    logic [7:0] pkt_byte, buf_wr_data, exp_data;
    uoed_hs_t hs_code;
    logic [1:0] hs_seen;
    logic [10:0] buf_wr_addr, exp_addr;
    int bad_count = 0, checks_done = 0, wr_cnt = 0, hs_cnt = 0, cyc = 0;

    always #2.5 aclk = ~aclk;

    uoed_top uoed_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pkt_start(pkt_start), .pkt_ep(pkt_ep),
        .pkt_byte_valid(pkt_byte_valid), .pkt_byte(pkt_byte), .pkt_end(pkt_end),
        .pkt_ready(pkt_ready), .hs_valid(hs_valid), .hs_code(hs_code),
        .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data));

    uoed_host_model uoed_host_model_i (.aclk(aclk), .pkt_ready(pkt_ready),
        .pkt_start(pkt_start), .pkt_ep(pkt_ep), .pkt_byte_valid(pkt_byte_valid),
        .pkt_byte(pkt_byte), .pkt_end(pkt_end));

    // ======================================================================
    // compare and closing report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard, well above the several hundred cycles the tests need
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // ======================================================================
    // register bus master
    function automatic logic [6:0] ra(input logic [1:0] ep, input logic [2:0] ofs);
        return {ep, ofs, 2'b00};
    endfunction

    task automatic axi_wr(input logic [6:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [6:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, ed});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // ======================================================================
    // buffer write and handshake monitor
    always @(posedge aclk) begin
        if (buf_wr_en === 1'b1) begin
            chk({21'h0, buf_wr_addr}, {21'h0, exp_addr});
            chk({24'h0, buf_wr_data}, {24'h0, exp_data});
            exp_addr <= exp_addr + 11'h001;
            exp_data <= exp_data + 8'h01;
            wr_cnt <= wr_cnt + 1;
        end
        if (hs_valid === 1'b1) begin
            hs_seen <= hs_code;
            hs_cnt <= hs_cnt + 1;
        end
    end

    // one packet: expected start address, bytes stored and handshake
    task automatic pkt(input logic [1:0] ep, input int n, input logic [7:0] first,
                       input int gap, input logic [10:0] a0, input int nw, input uoed_hs_t hs);
        int w0, h0;
        w0 = wr_cnt;
        h0 = hs_cnt;
        exp_addr = a0;
        exp_data = first;
        hs_seen = HS_NONE;      // stays so when no handshake is due
        uoed_host_model_i.send(ep, n, first, gap);
        repeat (4) @(posedge aclk);
        chk(wr_cnt - w0, nw);
        chk(hs_cnt - h0, (hs == HS_NONE) ? 0 : 1);
        chk({30'h0, hs_seen}, {30'h0, hs});
    endtask

    // ======================================================================
    // main sequence
    localparam logic [2:0] OFS_L[5] = '{OFS_X_BASE, OFS_X_COUNT, OFS_Y_BASE,
                                        OFS_Y_COUNT, OFS_SIZE};
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // reset values, write and read back, size bit 7 kept clear
        for (int e = 1; e < 4; e++) begin
            for (int k = 0; k < 5; k++) begin
                axi_rd(ra(e[1:0], OFS_L[k]), DESC_RESET, RESP_OKAY);
                axi_wr(ra(e[1:0], OFS_L[k]), {3'b100, e[1:0], OFS_L[k]}, RESP_OKAY);
                axi_rd(ra(e[1:0], OFS_L[k]), {k != 4, 2'b00, e[1:0], OFS_L[k]}, RESP_OKAY);
            end
        end
        // spare and endpoint zero places are refused
        axi_wr(ra(2'h1, OFS_SPARE_A), 8'h55, RESP_SLVERR);
        axi_rd(ra(2'h1, OFS_SPARE_A), 8'h00, RESP_SLVERR);
        axi_rd(ra(2'h2, OFS_SPARE_B), 8'h00, RESP_SLVERR);
        axi_rd(ra(EP_NONE, OFS_X_BASE), 8'h00, RESP_SLVERR);
        // single buffer on endpoint 1, then a second packet while full
        axi_wr(ra(2'h1, OFS_CONFIG), 8'h80, RESP_OKAY);
        axi_wr(ra(2'h1, OFS_X_BASE), 8'h12, RESP_OKAY);
        axi_wr(ra(2'h1, OFS_X_COUNT), 8'h00, RESP_OKAY);
        axi_wr(ra(2'h1, OFS_SIZE), 8'h40, RESP_OKAY);
        pkt(2'h1, 3, 8'h30, 0, 11'h090, 3, HS_ACK);
        axi_rd(ra(2'h1, OFS_X_COUNT), 8'h83, RESP_OKAY);
        pkt(2'h1, 2, 8'h40, 1, 11'h090, 0, HS_NAK);
        axi_rd(ra(2'h1, OFS_X_COUNT), 8'h83, RESP_OKAY);
        axi_rd(ra(2'h1, OFS_X_BASE), 8'h12, RESP_OKAY);
        // clock enable low for three edges freezes the read pipeline
        fork
            axi_rd(ra(2'h1, OFS_X_BASE), 8'h12, RESP_OKAY);
            begin
                repeat (2) @(posedge aclk);
                ce <= 1'b0;
                repeat (3) @(posedge aclk);
                ce <= 1'b1;
                chk({31'h0, s_axi_rvalid}, 32'h0);
            end
        join
        // double buffer on endpoint 2 with toggle set selects y
        axi_wr(ra(2'h2, OFS_CONFIG), 8'hb0, RESP_OKAY);
        axi_wr(ra(2'h2, OFS_Y_BASE), 8'h20, RESP_OKAY);
        axi_wr(ra(2'h2, OFS_Y_COUNT), 8'h00, RESP_OKAY);
        axi_wr(ra(2'h2, OFS_SIZE), 8'h40, RESP_OKAY);
        pkt(2'h2, 5, 8'h50, 1, 11'h100, 5, HS_ACK);
        axi_rd(ra(2'h2, OFS_Y_COUNT), 8'h85, RESP_OKAY);
        axi_rd(ra(2'h2, OFS_Y_BASE), 8'h20, RESP_OKAY);
        axi_rd(ra(2'h2, OFS_CONFIG), 8'h90, RESP_OKAY);
        // stall flag on endpoint 3
        axi_wr(ra(2'h3, OFS_CONFIG), 8'h88, RESP_OKAY);
        axi_wr(ra(2'h3, OFS_X_COUNT), 8'h00, RESP_OKAY);
        pkt(2'h3, 2, 8'h60, 0, 11'h000, 0, HS_STALL);
        // tiny buffer at the top of memory, then a full 64 byte packet
        axi_wr(ra(2'h3, OFS_CONFIG), 8'h80, RESP_OKAY);
        axi_wr(ra(2'h3, OFS_X_BASE), 8'hff, RESP_OKAY);
        axi_wr(ra(2'h3, OFS_SIZE), 8'h02, RESP_OKAY);
        pkt(2'h3, 4, 8'h70, 0, 11'h7f8, 2, HS_ACK);
        axi_wr(ra(2'h3, OFS_X_BASE), 8'h40, RESP_OKAY);
        axi_wr(ra(2'h3, OFS_X_COUNT), 8'h00, RESP_OKAY);
        axi_wr(ra(2'h3, OFS_SIZE), 8'h40, RESP_OKAY);
        pkt(2'h3, 64, 8'h00, 0, 11'h200, 64, HS_ACK);
        axi_rd(ra(2'h3, OFS_X_COUNT), 8'hc0, RESP_OKAY);
        // disabled endpoint and endpoint zero drain with no handshake
        axi_wr(ra(2'h3, OFS_CONFIG), 8'h00, RESP_OKAY);
        pkt(2'h3, 2, 8'h10, 0, 11'h000, 0, HS_NONE);
        pkt(EP_NONE, 2, 8'h10, 0, 11'h000, 0, HS_NONE);
        axi_rd(ra(2'h3, OFS_X_COUNT), 8'hc0, RESP_OKAY);
        finish_test();
    end
endmodule
